// ---- hdl/sgrc_ctrl_if.sv ----
// Control bundle between the register slave and the reset sequencer
`timescale 1ns/1ps
`default_nettype none
interface sgrc_ctrl_if;
    logic block_rst_req;
    logic block_rst_busy;
    modport regs (output block_rst_req, input block_rst_busy);
    modport seq  (input block_rst_req, output block_rst_busy);
endinterface
`default_nettype wire

// ---- hdl/sgrc_pkg.sv ----
// Constants and types for the SGMII reset and control register bank
// Notes on behaviour
// - While txrx_hold_reset is one, transmit and receive logic stays in reset.
// - Transmit and receive leave reset when software writes zero to that bit or a block reset clears it.
// - Writing one to block reset resets all adaptation logic; block_reset rises one pclk cycle after the write.
// - The block reset bit always reads as zero.
// - Reserved bits of both registers read as zero.
// - Leader mode takes speed and duplex from local word, else partner word.
// - Exactly one side of a direct link sets leader; works with or without autoneg.
// - Internal wrap clocks transmit and receive from the transmit clock.
// - Writing one then zero to autoneg_restart restarts auto-negotiation.
// - autoneg_enable one enables auto-negotiation; zero leaves it disabled.
// - Every writable bit of both registers resets to zero.
// - Ability words follow the serial GMII config word layout, 16 bits.
package sgrc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  SGRC_OFS_RESET    = 8'h04;
    localparam logic [7:0]  SGRC_OFS_CONTROL  = 8'h10;
    localparam logic [7:0]  SGRC_OFS_LOCAL    = 8'h18;
    localparam logic [7:0]  SGRC_OFS_PARTNER  = 8'h20;

    localparam int SGRC_BIT_BLOCK_RST  = 0;
    localparam int SGRC_BIT_TXRX_RST   = 1;
    localparam int SGRC_BIT_AN_ENABLE  = 0;
    localparam int SGRC_BIT_AN_RESTART = 1;
    localparam int SGRC_BIT_WRAP       = 4;
    localparam int SGRC_BIT_LEADER     = 5;

    // ------------------------------------------------------------
    // Ability word layout
    // ------------------------------------------------------------
    localparam int SGRC_ABL_W      = 16;
    localparam int SGRC_ABL_DUPLEX = 12;
    localparam int SGRC_ABL_SPD_HI = 11;
    localparam int SGRC_ABL_SPD_LO = 10;

    localparam logic [31:0] SGRC_ZERO_WORD  = 32'h0000_0000;
    localparam logic [15:0] SGRC_ABL_RESET  = 16'h0000;
    localparam logic [3:0]  SGRC_PULSE_RST  = 4'h0;
    localparam logic [3:0]  SGRC_PULSE_ONE  = 4'h1;

    // Default length of the sequencer busy pulse, in pclk cycles; block_reset stays high one cycle longer
    localparam int SGRC_PULSE_CYCLES = 8;

    typedef enum logic [1:0] {
        SGRC_SPD_10M  = 2'b00,
        SGRC_SPD_100M = 2'b01,
        SGRC_SPD_1G   = 2'b10,
        SGRC_SPD_RSVD = 2'b11
    } sgrc_speed_t;

    typedef enum {
        SGRC_RUN,
        SGRC_PULSE
    } sgrc_rst_state_t;

endpackage

// ---- hdl/sgrc_regs.sv ----
// SGMII reset and control register bank with APB slave
`timescale 1ns/1ps
`default_nettype none
module sgrc_regs
    import sgrc_pkg::*;
#(
    parameter int PULSE_CYCLES = sgrc_pkg::SGRC_PULSE_CYCLES
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [sgrc_pkg::SGRC_ABL_W-1:0] partner_ability_word,
    input  wire logic                        tx_clk_sel_in,
    output logic                             block_reset,
    output logic                             txrx_reset,
    output logic                             autoneg_enable,
    output logic                             autoneg_restart,
    output logic                             wrap_clk_sel,
    output logic                             leader_mode,
    output logic [1:0]                       link_speed,
    output logic                             link_full_duplex
);
    import sgrc_pkg::*;

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    sgrc_ctrl_if ctl ();

    sgrc_reset_seq #(
        .PULSE_CYCLES (PULSE_CYCLES)
    ) u_seq (
        .pclk    (pclk),
        .presetn (presetn),
        .ctl     (ctl)
    );

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic        txrx_q, txrx_d;
    logic        an_en_q, an_en_d;
    logic        an_rst_q, an_rst_d;
    logic        wrap_q, wrap_d;
    logic        leader_q, leader_d;
    logic        an_kick_q, an_kick_d;
    logic [15:0] local_q, local_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic        blk_q, blk_d;
    logic        txrx_out_q, txrx_out_d;
    logic [1:0]  spd_q, spd_d;
    logic        dup_q, dup_d;
    logic [15:0] part_s1_q, part_s2_q;
    logic        wrap_s1_q, wrap_s2_q;
    logic        req_q, req_d;

    logic        setup;
    logic        wr_en;
    logic        hit;
    logic [15:0] sel_word;

    assign setup = psel && !penable;
    // No wait state: pready answers in the cycle after setup
    assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
    assign hit   = (paddr == SGRC_OFS_RESET) || (paddr == SGRC_OFS_CONTROL)
                || (paddr == SGRC_OFS_LOCAL) || (paddr == SGRC_OFS_PARTNER);

    assign sel_word = leader_q ? local_q : part_s2_q;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        txrx_d    = txrx_q;
        an_en_d   = an_en_q;
        an_rst_d  = an_rst_q;
        wrap_d    = wrap_q;
        leader_d  = leader_q;
        local_d   = local_q;
        an_kick_d = 1'b0;
        req_d     = 1'b0;
        pready_d  = 1'b0;
        pslverr_d = pslverr_q;
        prdata_d  = prdata_q;

        if (setup) begin
            pready_d  = 1'b1;
            pslverr_d = !hit;
            prdata_d  = SGRC_ZERO_WORD;
            if (!pwrite) begin
                unique case (paddr)
                    SGRC_OFS_RESET: begin
                        // Block reset bit reads zero
                        prdata_d[SGRC_BIT_TXRX_RST] = txrx_q;
                    end
                    SGRC_OFS_CONTROL: begin
                        prdata_d[SGRC_BIT_AN_ENABLE]  = an_en_q;
                        prdata_d[SGRC_BIT_AN_RESTART] = an_rst_q;
                        prdata_d[SGRC_BIT_WRAP]       = wrap_q;
                        prdata_d[SGRC_BIT_LEADER]     = leader_q;
                    end
                    SGRC_OFS_LOCAL:   prdata_d[SGRC_ABL_W-1:0] = local_q;
                    SGRC_OFS_PARTNER: prdata_d[SGRC_ABL_W-1:0] = part_s2_q;
                    default:          prdata_d = SGRC_ZERO_WORD;
                endcase
            end
        end else if (psel && penable) begin
            pready_d = 1'b0;
        end else begin
            pslverr_d = 1'b0;
        end

        if (wr_en) begin
            unique case (paddr)
                SGRC_OFS_RESET: begin
                    if (pstrb[0]) begin
                        txrx_d = pwdata[SGRC_BIT_TXRX_RST];
                        req_d  = pwdata[SGRC_BIT_BLOCK_RST];
                    end
                end
                SGRC_OFS_CONTROL: begin
                    if (pstrb[0]) begin
                        an_en_d  = pwdata[SGRC_BIT_AN_ENABLE];
                        an_rst_d = pwdata[SGRC_BIT_AN_RESTART];
                        wrap_d   = pwdata[SGRC_BIT_WRAP];
                        leader_d = pwdata[SGRC_BIT_LEADER];
                        // Restart fires on the falling write only
                        an_kick_d = an_rst_q && !pwdata[SGRC_BIT_AN_RESTART];
                    end
                end
                SGRC_OFS_LOCAL: begin
                    if (pstrb[0]) local_d[7:0]  = pwdata[7:0];
                    if (pstrb[1]) local_d[15:8] = pwdata[15:8];
                end
                default: begin
                end
            endcase
        end

        // Block reset clears every writable bit too
        if (ctl.block_rst_busy) begin
            txrx_d   = 1'b0;
            an_en_d  = 1'b0;
            an_rst_d = 1'b0;
            wrap_d   = 1'b0;
            leader_d = 1'b0;
            local_d  = SGRC_ABL_RESET;
        end

        blk_d      = req_q || ctl.block_rst_busy;
        txrx_out_d = txrx_q || blk_d;
        spd_d      = sel_word[SGRC_ABL_SPD_HI:SGRC_ABL_SPD_LO];
        dup_d      = sel_word[SGRC_ABL_DUPLEX];
    end

    assign ctl.block_rst_req = req_q;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txrx_q     <= 1'b0;
            an_en_q    <= 1'b0;
            an_rst_q   <= 1'b0;
            wrap_q     <= 1'b0;
            leader_q   <= 1'b0;
            an_kick_q  <= 1'b0;
            local_q    <= SGRC_ABL_RESET;
            prdata_q   <= SGRC_ZERO_WORD;
            pready_q   <= 1'b0;
            pslverr_q  <= 1'b0;
            blk_q      <= 1'b0;
            txrx_out_q <= 1'b0;
            spd_q      <= SGRC_SPD_10M;
            dup_q      <= 1'b0;
            part_s1_q  <= SGRC_ABL_RESET;
            part_s2_q  <= SGRC_ABL_RESET;
            wrap_s1_q  <= 1'b0;
            wrap_s2_q  <= 1'b0;
            req_q      <= 1'b0;
        end else begin
            txrx_q     <= txrx_d;
            an_en_q    <= an_en_d;
            an_rst_q   <= an_rst_d;
            wrap_q     <= wrap_d;
            leader_q   <= leader_d;
            an_kick_q  <= an_kick_d;
            local_q    <= local_d;
            prdata_q   <= prdata_d;
            pready_q   <= pready_d;
            pslverr_q  <= pslverr_d;
            blk_q      <= blk_d;
            txrx_out_q <= txrx_out_d;
            spd_q      <= spd_d;
            dup_q      <= dup_d;
            part_s1_q  <= partner_ability_word;
            part_s2_q  <= part_s1_q;
            wrap_s1_q  <= tx_clk_sel_in;
            wrap_s2_q  <= wrap_s1_q;
            req_q      <= req_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign block_reset      = blk_q;
    assign txrx_reset       = txrx_out_q;
    assign autoneg_enable   = an_en_q;
    assign autoneg_restart  = an_kick_q;
    // Selects the transmit clock for both paths while set
    assign wrap_clk_sel     = wrap_q;
    assign leader_mode      = leader_q;
    assign link_speed       = spd_q;
    assign link_full_duplex = dup_q;

    logic unused_wrap;
    assign unused_wrap = wrap_s2_q;
endmodule // sgrc_regs
`default_nettype wire

// ---- hdl/sgrc_reset_seq.sv ----
// Block reset pulse sequencer
`timescale 1ns/1ps
`default_nettype none
module sgrc_reset_seq
    import sgrc_pkg::*;
#(
    parameter int PULSE_CYCLES = SGRC_PULSE_CYCLES
) (
    input  wire logic   pclk,
    input  wire logic   presetn,
    sgrc_ctrl_if.seq    ctl
);
    // Counter is four bits wide, so longer pulses cannot be served
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 15) begin : g_bad_pulse
        $error("PULSE_CYCLES out of range");
    end

    localparam logic [3:0] LAST = 4'(PULSE_CYCLES);

    sgrc_rst_state_t state_q, state_d;
    logic [3:0]      cnt_q, cnt_d;

    // ------------------------------------------------------------
    // Pulse sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            SGRC_RUN: begin
                if (ctl.block_rst_req) begin
                    state_d = SGRC_PULSE;
                    cnt_d   = SGRC_PULSE_ONE;
                end
            end
            SGRC_PULSE: begin
                // Held long enough to clear every flop downstream
                if (cnt_q >= LAST) begin
                    state_d = SGRC_RUN;
                    cnt_d   = SGRC_PULSE_RST;
                end else begin
                    cnt_d = cnt_q + SGRC_PULSE_ONE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SGRC_RUN;
            cnt_q   <= SGRC_PULSE_RST;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign ctl.block_rst_busy = (state_q == SGRC_PULSE);
endmodule // sgrc_reset_seq
`default_nettype wire

// ---- testbench/sgmii_reset_control_regs_tb.sv ----
// Self-checking bench for the SGMII reset and control register bank
`timescale 1ns/1ps
`default_nettype none
module sgmii_reset_control_regs_tb;
    import sgrc_pkg::*;
    localparam int PULSE = 4;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'h0;
    logic        pready, pslverr, block_reset, txrx_reset, autoneg_enable;
    logic        autoneg_restart, wrap_clk_sel, leader_mode, link_full_duplex;
    logic [1:0]  link_speed, lp_speed = 2'b10;
    logic        lp_full = 1'b1;
    logic [15:0] partner_ability_word;
    int          miscompares = 0, cmp_count = 0;
    sgrc_link_partner i_lp (.pclk, .presetn, .speed(lp_speed), .full(lp_full),
        .partner_ability_word);
    sgrc_regs #(.PULSE_CYCLES(PULSE)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .partner_ability_word,
        .tx_clk_sel_in(1'b0), .block_reset, .txrx_reset, .autoneg_enable,
        .autoneg_restart, .wrap_clk_sel, .leader_mode, .link_speed, .link_full_duplex);
    initial forever #5 pclk = ~pclk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            $display("BAD pready expected 1 seen %b", pready);
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic t_reset_vals;
        apb(0, SGRC_OFS_RESET, 0);   chk("reset reg", 0, rd);
        apb(0, SGRC_OFS_CONTROL, 0); chk("control reg", 0, rd);
        apb(0, SGRC_OFS_LOCAL, 0);   chk("local word", 0, rd);
        apb(0, 8'h08, 0);            chk("unmapped err", 1, err);
    endtask
    task automatic t_txrx;
        apb(1, SGRC_OFS_RESET, 32'h2); cyc(3); chk("txrx on", 1, txrx_reset);
        apb(0, SGRC_OFS_RESET, 0); chk("txrx bit", 32'h2, rd);
        apb(1, SGRC_OFS_CONTROL, 32'h10); cyc(3); chk("wrap on", 1, wrap_clk_sel);
        chk("txrx held", 1, txrx_reset);
        apb(1, SGRC_OFS_RESET, 0); cyc(3); chk("txrx off", 0, txrx_reset);
        apb(1, SGRC_OFS_CONTROL, 0); cyc(3); chk("wrap off", 0, wrap_clk_sel);
    endtask
    task automatic t_ctrl;
        int n = 0;
        apb(1, SGRC_OFS_CONTROL, 32'hFFFF_FFFD); apb(0, SGRC_OFS_CONTROL, 0);
        chk("control rsvd", 32'h31, rd);
        chk("an enable", 1, autoneg_enable);
        apb(1, SGRC_OFS_CONTROL, 32'h3); apb(1, SGRC_OFS_CONTROL, 32'h1);
        while (autoneg_restart !== 1'b1 && n < 4) begin @(posedge pclk); n++; end
        chk("restart pulse", 1, autoneg_restart);
        apb(1, SGRC_OFS_CONTROL, 0); cyc(3); chk("an disable", 0, autoneg_enable);
    endtask
    task automatic t_block;
        int n = 0;
        apb(1, SGRC_OFS_CONTROL, 32'h31); apb(1, SGRC_OFS_RESET, 32'h3);
        while (block_reset !== 1'b1 && n < 5) begin @(posedge pclk); n++; end
        n = 0;
        while (block_reset === 1'b1 && n < 40) begin @(posedge pclk); n++; end
        chk("pulse cycles", PULSE + 1, n);
        apb(0, SGRC_OFS_RESET, 0);   chk("reset after", 0, rd);
        apb(0, SGRC_OFS_CONTROL, 0); chk("control after", 0, rd);
        chk("txrx after", 0, txrx_reset);
    endtask
    task automatic t_leader;
        apb(1, SGRC_OFS_LOCAL, 32'h0000_0401); apb(1, SGRC_OFS_CONTROL, 32'h20); cyc(8);
        chk("leader on", 1, leader_mode);
        chk("lead speed", 2'b01, link_speed);
        chk("lead duplex", 0, link_full_duplex);
        apb(0, SGRC_OFS_PARTNER, 0);
        chk("partner word", {2'b11, 1'b0, lp_full, lp_speed, 10'h1}, rd);
        apb(1, SGRC_OFS_CONTROL, 0); cyc(8);
        chk("leader off", 0, leader_mode);
        chk("follow speed", lp_speed, link_speed);
        chk("follow duplex", lp_full, link_full_duplex);
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        tally_and_finish;
    end
    initial begin
        cyc(2);
        presetn <= 1;
        t_reset_vals;
        t_txrx;
        t_ctrl;
        t_block;
        t_leader;
        tally_and_finish;
    end
endmodule // sgmii_reset_control_regs_tb
bind sgrc_regs sgrc_regs_properties #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .block_reset,
    .txrx_reset, .autoneg_enable, .autoneg_restart, .wrap_clk_sel, .leader_mode,
    .link_speed);
`default_nettype wire

// ---- testbench/sgrc_link_partner.sv ----
// Behavioural far-side partner advertising its ability word
`timescale 1ns/1ps
`default_nettype none
module sgrc_link_partner (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [1:0]  speed,
    input  wire logic        full,
    output logic      [15:0] partner_ability_word
);
    // Partner stays in follower mode, so the local side may lead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) partner_ability_word <= 16'h0000;
        else partner_ability_word <= {2'b11, 1'b0, full, speed, 9'h000, 1'b1};
    end
endmodule // sgrc_link_partner
`default_nettype wire

// ---- testbench/sgrc_regs_properties.sv ----
// Port-level checks for the SGMII reset and control register bank
`timescale 1ns/1ps
`default_nettype none
module sgrc_regs_properties
    import sgrc_pkg::*;
#(
    parameter int PULSE_CYCLES = SGRC_PULSE_CYCLES
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        block_reset,
    input wire logic        txrx_reset,
    input wire logic        autoneg_enable,
    input wire logic        autoneg_restart,
    input wire logic        wrap_clk_sel,
    input wire logic        leader_mode,
    input wire logic [1:0]  link_speed
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       acc;
    logic       wr_rst;
    logic       wr_ctl;
    logic       wr_clr;
    logic [4:0] hi_q;
    logic [4:0] hi_d;
    assign acc    = psel && penable && pready;
    assign wr_rst = acc && pwrite && pstrb[0] && paddr == SGRC_OFS_RESET;
    assign wr_ctl = acc && pwrite && pstrb[0] && paddr == SGRC_OFS_CONTROL;
    assign wr_clr = wr_ctl && !pwdata[1];
    // Length of the current block reset pulse
    always_comb hi_d = block_reset ? hi_q + 5'h01 : 5'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hi_q <= 5'h00;
        else hi_q <= hi_d;
    end
    txrx_hold_a: assert property (wr_rst && pwdata[1] |-> ##[1:2] txrx_reset)
        else $error("txrx reset not raised");
    blk_start_a: assert property (wr_rst && pwdata[0] |-> ##[1:2] block_reset)
        else $error("block reset not raised");
    blk_len_a: assert property ($fell(block_reset) |-> hi_q == PULSE_CYCLES + 1)
        else $error("block reset pulse length wrong");
    rst_read_a: assert property (acc && !pwrite && paddr == SGRC_OFS_RESET
        |-> prdata[0] == 1'b0 && prdata[31:2] == 30'h0)
        else $error("reset register read not zero");
    ctl_read_a: assert property (acc && !pwrite && paddr == SGRC_OFS_CONTROL
        |-> prdata[31:6] == 26'h0 && prdata[3:2] == 2'h0)
        else $error("control reserved bits not zero");
    restart_a: assert property (autoneg_restart |-> !$past(autoneg_restart)
        && ($past(wr_clr) || $past(wr_clr, 2)))
        else $error("restart pulse without clearing write");
    an_enable_a: assert property (wr_ctl && pwdata[0] |-> ##[1:2] autoneg_enable)
        else $error("autoneg enable not set");
    wrap_sel_a: assert property (wr_ctl && pwdata[4] |-> ##[1:2] wrap_clk_sel)
        else $error("wrap clock select not set");
    reset_zero_a: assert property ($rose(presetn) |-> !block_reset && !txrx_reset
        && !autoneg_enable && !wrap_clk_sel && !leader_mode)
        else $error("output not zero after reset");
    cover property ($fell(block_reset));
    cover property (autoneg_restart);
    cover property (wrap_clk_sel && txrx_reset);
    cover property (leader_mode && link_speed == 2'h1);
endmodule // sgrc_regs_properties
`default_nettype wire
